// >>> design/rrsp_params.svh
// Timing and reset constants for the remote run synchronisation port
`ifndef RRSP_PARAMS_SVH
`define RRSP_PARAMS_SVH

`define RRSP_CLK_FREQ_HZ      40000000
`define RRSP_START_MIN_US     500
`define RRSP_RELAY_MS         120
`define RRSP_START_DRIVE_US   1000
`define RRSP_MAX_PARTICIPANTS 10
// Every conversion truncates cycles per unit, so all times round down
`define RRSP_START_MIN_CYC (`RRSP_START_MIN_US * (`RRSP_CLK_FREQ_HZ / 1000000))
`define RRSP_RELAY_CYC     (`RRSP_RELAY_MS * (`RRSP_CLK_FREQ_HZ / 1000))
`define RRSP_DRIVE_CYC     (`RRSP_START_DRIVE_US * (`RRSP_CLK_FREQ_HZ / 1000000))
`define RRSP_LINE_RELEASED 1'b1

`endif

// >>> design/rrsp_pkg.sv
// Types for the remote run synchronisation port
package rrsp_pkg;
  typedef enum logic [1:0] {
    RRSP_IDLE,
    RRSP_PREP,
    RRSP_RUN
  } rrsp_state_e;
endpackage

// >>> design/rrsp_port.sv
// Remote run synchronisation port: shared open-collector run lines
// Contract
// - Each remote line is only pulled low or released; released floats high.
// - Sampled low level is logic zero, high level is logic one.
// - Shared bus links at most ten instruments in parallel.
// - Low prepare line puts the device into pre-run preparation.
// - Ready released high only while able to start next analysis.
// - Low start line requests run and timed event table start.
// - Start recognised only after low pulse of at least 500 us.
// - On run start, close isolated start contact for 120 ms.
// - Low stop line ends or aborts run and halts injection.
// - Local start or stop is also asserted on the shared lines.
`timescale 1ns/1ps
`include "rrsp_params.svh"

module rrsp_port #(
  parameter int unsigned START_MIN_CYC = `RRSP_START_MIN_CYC,
  parameter int unsigned RELAY_CYC     = `RRSP_RELAY_CYC,
  parameter int unsigned DRIVE_CYC     = `RRSP_DRIVE_CYC
) (
  input  wire logic clk_i,
  input  wire logic srst_i,
  input  wire logic prep_line_i,
  input  wire logic start_line_i,
  input  wire logic stop_line_i,
  input  wire logic ready_line_i,
  output logic      start_line_o,
  output logic      start_line_oe_n_o,
  output logic      stop_line_o,
  output logic      stop_line_oe_n_o,
  output logic      ready_line_o,
  output logic      ready_line_oe_n_o,
  input  wire logic local_start_i,
  input  wire logic local_stop_i,
  input  wire logic inst_able_i,
  input  wire logic run_done_i,
  output logic      prep_active_o,
  output logic      run_active_o,
  output logic      run_begin_o,
  output logic      halt_inject_o,
  output logic      start_contact_o
);

  localparam int CW = 32;

  // Two-stage synchronisers; first stage read only by second
  // Reset to released level so no false request follows reset
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      sync1_r[2] <= 1'b1;
      sync2_r[2] <= 1'b1;
    end
    else
    begin
      sync1_r[2] <= prep_line_i;
      sync2_r[2] <= sync1_r[2];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      sync1_r[1] <= 1'b1;
      sync2_r[1] <= 1'b1;
    end
    else
    begin
      sync1_r[1] <= start_line_i;
      sync2_r[1] <= sync1_r[1];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      sync1_r[0] <= 1'b1;
      sync2_r[0] <= 1'b1;
    end
    else
    begin
      sync1_r[0] <= stop_line_i;
      sync2_r[0] <= sync1_r[0];
    end
  end

  // Low level is logic zero, so low means asserted
  logic prep_req;
  logic start_low;
  logic stop_req;
  assign prep_req  = ~sync2_r[2];
  assign start_low = ~sync2_r[1];
  assign stop_req  = ~sync2_r[0];

  function automatic logic [CW-1:0] sat_inc(input logic [CW-1:0] v, input logic [CW-1:0] lim);
    sat_inc = (v >= lim) ? lim : v + 32'h1;
  endfunction

  // Own drives, declared early: the start counter is held clear while drive_start_r is set
  logic [CW-1:0] drive_cnt_r;
  logic          drive_start_r;
  logic [CW-1:0] stop_cnt_r;
  logic          stop_drive_r;

  // Start width measured on own clock; shorter glitches ignored
  logic [CW-1:0] start_cnt_r;
  logic          ext_start;

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      start_cnt_r <= '0;
    else if (start_low && !drive_start_r)
      start_cnt_r <= sat_inc(start_cnt_r, CW'(START_MIN_CYC));
    else
      start_cnt_r <= '0;
  end

  assign ext_start = (start_cnt_r == CW'(START_MIN_CYC) - 32'h1) && start_low;

  rrsp_pkg::rrsp_state_e state_r;
  rrsp_pkg::rrsp_state_e state_nxt;
  logic                  go;
  logic                  halt;

  assign halt = stop_req || local_stop_i || stop_drive_r;
  assign go   = (ext_start || local_start_i) && !halt && state_r != rrsp_pkg::RRSP_RUN;

  // Next state kept apart so status outputs show it without lag
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      rrsp_pkg::RRSP_IDLE:
      begin
        if (go)
          state_nxt = rrsp_pkg::RRSP_RUN;
        else if (prep_req && !halt)
          state_nxt = rrsp_pkg::RRSP_PREP;
      end
      rrsp_pkg::RRSP_PREP:
      begin
        if (halt)
          state_nxt = rrsp_pkg::RRSP_IDLE;
        else if (go)
          state_nxt = rrsp_pkg::RRSP_RUN;
      end
      rrsp_pkg::RRSP_RUN:
      begin
        if (halt || run_done_i)
          state_nxt = rrsp_pkg::RRSP_IDLE;
      end
      default:
        state_nxt = rrsp_pkg::RRSP_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      state_r <= rrsp_pkg::RRSP_IDLE;
    else
      state_r <= state_nxt;
  end

  // Own start drive, held so linked units see a valid width
  // Loaded one short: the registered enable adds the last cycle
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      drive_cnt_r   <= '0;
      drive_start_r <= 1'b0;
    end
    else if (go && local_start_i)
    begin
      drive_cnt_r   <= CW'(DRIVE_CYC) - 32'h1;
      drive_start_r <= 1'b1;
    end
    else if (drive_cnt_r > 32'h1)
      drive_cnt_r <= drive_cnt_r - 32'h1;
    else
    begin
      drive_cnt_r   <= '0;
      drive_start_r <= 1'b0;
    end
  end

  // Local stop pulls stop line for the same drive time
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      stop_cnt_r   <= '0;
      stop_drive_r <= 1'b0;
    end
    else if (local_stop_i)
    begin
      stop_cnt_r   <= CW'(DRIVE_CYC) - 32'h1;
      stop_drive_r <= 1'b1;
    end
    else if (stop_cnt_r > 32'h1)
      stop_cnt_r <= stop_cnt_r - 32'h1;
    else
    begin
      stop_cnt_r   <= '0;
      stop_drive_r <= 1'b0;
    end
  end

  // Isolated contact closes for fixed time on every run start
  logic [CW-1:0] relay_cnt_r;

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      relay_cnt_r     <= '0;
      start_contact_o <= 1'b0;
    end
    else if (go)
    begin
      relay_cnt_r     <= CW'(RELAY_CYC);
      start_contact_o <= 1'b1;
    end
    else if (relay_cnt_r > 32'h1)
      relay_cnt_r <= relay_cnt_r - 32'h1;
    else
    begin
      relay_cnt_r     <= '0;
      start_contact_o <= 1'b0;
    end
  end

  // Open-collector pins: data always low, enable decides pull
  // Only ever pulling low lets up to ten units share a wire
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      start_line_o      <= 1'b0;
      start_line_oe_n_o <= `RRSP_LINE_RELEASED;
    end
    else
    begin
      start_line_o      <= 1'b0;
      start_line_oe_n_o <= ~(go && local_start_i) & ~drive_start_r;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      stop_line_o      <= 1'b0;
      stop_line_oe_n_o <= `RRSP_LINE_RELEASED;
    end
    else
    begin
      stop_line_o      <= 1'b0;
      stop_line_oe_n_o <= ~(local_stop_i | stop_drive_r);
    end
  end

  // Ready held low from reset until the instrument says it can run
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      ready_line_o      <= 1'b0;
      ready_line_oe_n_o <= 1'b0;
    end
    else
    begin
      ready_line_o      <= 1'b0;
      ready_line_oe_n_o <= ~(!inst_able_i || state_nxt == rrsp_pkg::RRSP_RUN || halt);
    end
  end

  // Status taken from next state so it lines up with run_begin_o
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      prep_active_o <= 1'b0;
    else
      prep_active_o <= (state_nxt == rrsp_pkg::RRSP_PREP);
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      run_active_o <= 1'b0;
    else
      run_active_o <= (state_nxt == rrsp_pkg::RRSP_RUN);
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      run_begin_o <= 1'b0;
    else
      run_begin_o <= go;
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      halt_inject_o <= 1'b0;
    else
      halt_inject_o <= halt;
  end

endmodule

// >>> verif/rrsp_port_asserts.sv
// Concurrent checks on the run synchronisation port outputs
`timescale 1ns/1ps

module rrsp_port_asserts #(
  parameter int unsigned RELAY_CYC = 10,
  parameter int unsigned DRIVE_CYC = 30
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic start_line_i,
  input wire logic local_start_i,
  input wire logic local_stop_i,
  input wire logic start_line_o,
  input wire logic start_line_oe_n_o,
  input wire logic stop_line_oe_n_o,
  input wire logic ready_line_oe_n_o,
  input wire logic run_active_o,
  input wire logic run_begin_o,
  input wire logic halt_inject_o,
  input wire logic start_contact_o
);
  localparam int RLY_TAIL = RELAY_CYC - 7;
  localparam int DRV = DRIVE_CYC;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  sequence s_take;
    local_start_i && !run_active_o && !halt_inject_o;
  endsequence
  // Contact closed for 8 cycles, then open RLY_TAIL cycles later
  sequence s_close;
    start_contact_o [*8] ##RLY_TAIL !start_contact_o;
  endsequence
  a_local_start_run: assert property (s_take |=> run_begin_o && run_active_o)
    else $error("local start did not begin a run");
  a_begin_one_cycle: assert property (run_begin_o |=> !run_begin_o)
    else $error("run begin pulse too long");
  a_contact_relay_len: assert property (run_begin_o |-> s_close)
    else $error("start contact timing wrong");
  a_own_start_drive: assert property (s_take |=> !start_line_oe_n_o ##DRV start_line_oe_n_o)
    else $error("own start drive timing wrong");
  a_line_data_low: assert property (!start_line_o)
    else $error("start line data not low");
  a_ready_held_run: assert property (run_active_o |-> !ready_line_oe_n_o)
    else $error("ready released during a run");
  a_reset_levels: assert property ($fell(srst_i) |-> !ready_line_oe_n_o && start_line_oe_n_o)
    else $error("line enables wrong after reset");
  a_ext_start_min: assert property ($fell(start_line_i) && !run_active_o |-> !run_begin_o [*5])
    else $error("external start taken too early");
  a_local_stop_halt: assert property (local_stop_i |=> halt_inject_o && !stop_line_oe_n_o)
    else $error("local stop did not halt");
endmodule

bind rrsp_port rrsp_port_asserts #(.RELAY_CYC(RELAY_CYC), .DRIVE_CYC(DRIVE_CYC)) u_rrsp_port_asserts
  (.clk_i, .srst_i, .start_line_i, .local_start_i, .local_stop_i, .start_line_o,
   .start_line_oe_n_o, .stop_line_oe_n_o, .ready_line_oe_n_o, .run_active_o,
   .run_begin_o, .halt_inject_o, .start_contact_o);

// >>> verif/rrsp_peer.sv
// Model of another linked instrument on the shared run lines
`timescale 1ns/1ps

module rrsp_peer (
  input  wire logic clk_i,
  input  wire logic start_line_oe_n_i,
  input  wire logic stop_line_oe_n_i,
  input  wire logic ready_line_oe_n_i,
  output logic      prep_line_o,
  output logic      start_line_o,
  output logic      stop_line_o,
  output logic      ready_line_o
);
  logic [2:0] pull_r = 3'h0;
  // Wired-AND with passive pull-up: any party pulling wins
  assign prep_line_o  = !pull_r[0];
  assign start_line_o = start_line_oe_n_i && !pull_r[1];
  assign stop_line_o  = stop_line_oe_n_i && !pull_r[2];
  assign ready_line_o = ready_line_oe_n_i;
  // Line 0 prepare, 1 start, 2 stop; held low n cycles
  task pulse(input int line, input int n);
    pull_r[line] <= 1'b1;
    repeat (n) @(posedge clk_i);
    pull_r[line] <= 1'b0;
  endtask
endmodule

// >>> verif/rrsp_port_tb.sv
// Self-checking bench for the remote run synchronisation port
`timescale 1ns/1ps

module rrsp_port_tb;
  typedef struct {int width; logic run;} rrsp_row_s;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic local_start_i = 1'b0;
  logic local_stop_i = 1'b0;
  logic inst_able_i = 1'b0;
  logic run_done_i = 1'b0;
  wire  prep_line_i, start_line_i, stop_line_i, ready_line_i;
  wire  start_line_oe_n_o, stop_line_oe_n_o, ready_line_oe_n_o;
  wire  prep_active_o, run_active_o, run_begin_o, halt_inject_o, start_contact_o;
  int   fails = 0;
  int   comparisons = 0;
  int   cycles = 0;
  // Widths 2 and 3 sit below the four-cycle minimum
  rrsp_row_s rows [3] = '{'{2, 1'b0}, '{3, 1'b0}, '{10, 1'b1}};

  rrsp_port #(.START_MIN_CYC(4), .RELAY_CYC(10), .DRIVE_CYC(30)) u_rrsp_port
    (.*, .start_line_o(), .stop_line_o(), .ready_line_o());
  rrsp_peer u_rrsp_peer (.clk_i, .start_line_oe_n_i(start_line_oe_n_o),
    .stop_line_oe_n_i(stop_line_oe_n_o), .ready_line_oe_n_i(ready_line_oe_n_o),
    .prep_line_o(prep_line_i), .start_line_o(start_line_i),
    .stop_line_o(stop_line_i), .ready_line_o(ready_line_i));

  initial forever #12.5 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      fails++;
      conclude();
    end
  end

  task chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task conclude;
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task stop_run;
    tick(1);
    local_stop_i <= 1'b1;
    tick(1);
    local_stop_i <= 1'b0;
    @(negedge clk_i);
    chk(halt_inject_o, 8'h01);
    chk(stop_line_oe_n_o, 8'h00);
    tick(40);
    @(negedge clk_i);
    chk(run_active_o, 8'h00);
  endtask

  initial
  begin
    tick(16);
    srst_i <= 1'b0;
    @(negedge clk_i);
    chk(ready_line_oe_n_o, 8'h00);
    chk(start_line_oe_n_o, 8'h01);
    foreach (rows[i])
    begin
      tick(4);
      u_rrsp_peer.pulse(1, rows[i].width);
      tick(10);
      @(negedge clk_i);
      chk(run_active_o, rows[i].run);
      stop_run();
    end
    tick(1);
    inst_able_i <= 1'b1;
    tick(2);
    @(negedge clk_i);
    chk(ready_line_oe_n_o, 8'h01);
    tick(1);
    local_start_i <= 1'b1;
    tick(1);
    local_start_i <= 1'b0;
    @(negedge clk_i);
    chk({run_begin_o, start_line_oe_n_o, start_contact_o, ready_line_oe_n_o}, 8'h0A);
    tick(9);
    @(negedge clk_i);
    chk(start_contact_o, 8'h01);
    tick(1);
    @(negedge clk_i);
    chk(start_contact_o, 8'h00);
    stop_run();
    tick(1);
    u_rrsp_peer.pulse(0, 3);
    tick(3);
    @(negedge clk_i);
    chk(prep_active_o, 8'h01);
    tick(1);
    u_rrsp_peer.pulse(2, 3);
    tick(4);
    @(negedge clk_i);
    chk(prep_active_o, 8'h00);
    conclude();
  end
endmodule
